// ==== hdl/rrec_consts.svh ====
`ifndef RREC_CONSTS_SVH
`define RREC_CONSTS_SVH
// Register index of the control/status word
`define RREC_OFF_CTRL      5'h17
// Own registers: interrupt status and mask
`define RREC_OFF_IRQ_STAT  5'h1A
`define RREC_OFF_IRQ_MASK  5'h1B
// Reset value of the control/status word
`define RREC_CTRL_RST      16'h0041
// Field positions
`define RREC_B_TXSHIFT     8
`define RREC_B_REFSEL      7
`define RREC_B_RSVD6       6
`define RREC_B_RSVD5       5
`define RREC_B_REVSEL      4
`define RREC_B_OVF         3
`define RREC_B_UNF         2
`define RREC_B_SIZE_HI     1
`define RREC_B_SIZE_LO     0
// Writable bits of the control/status word
`define RREC_CTRL_WMASK    16'h01F3
// Interrupt bits
`define RREC_IRQ_OVF       0
`define RREC_IRQ_UNF       1
`define RREC_IRQ_W         2
// Tolerance depths in bits per size code
`define RREC_TOL0          5'h0E
`define RREC_TOL1          5'h02
`define RREC_TOL2          5'h06
`define RREC_TOL3          5'h0A
`define RREC_DEPTH         32
// Local read beat: one dibit out every eight clocks
`define RREC_BEAT_W        3
`define RREC_BEAT_LAST     3'h7
`endif

// ==== hdl/rrec_mem.sv ====
`timescale 1ns/1ps
// Small dibit store; read data leave through a register
module rrec_mem #(
  parameter int W = 2,
  parameter int D = 32,
  parameter int A = 5
) (
  input  wire logic         clk,
  input  wire logic         we,
  input  wire logic [A-1:0] waddr,
  input  wire logic [W-1:0] wdata,
  input  wire logic [A-1:0] raddr,
  output logic      [W-1:0] rdata
);
  logic [W-1:0] mem [D];    // Storage array
  initial begin
    if (D > (1 << A)) $error("rrec_mem depth exceeds address range");
  end
  // Write port
  always_ff @(posedge clk) begin
    if (we) mem[waddr] <= wdata;
  end
  // Registered read port
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule : rrec_mem

// ==== hdl/rrec_pkg.sv ====
package rrec_pkg;
  // Register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } rrec_bus_t;
  // One received dibit from the recovered domain
  typedef struct packed {
    logic       dv;
    logic [1:0] dibit;
  } rrec_rx_t;
  // Elasticity buffer size codes
  typedef enum logic [1:0] {
    RREC_SZ_14 = 2'h0,
    RREC_SZ_2  = 2'h1,
    RREC_SZ_6  = 2'h2,
    RREC_SZ_10 = 2'h3
  } rrec_size_t;
endpackage : rrec_pkg

// ==== hdl/rrec_top.sv ====
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "rrec_consts.svh"

// Notes on behaviour
// RULE1: Clock shift only acts in slave mode
// RULE2: Reference select loaded from strap, then writable
// RULE3: Select 0 is 25MHz, 1 is 50MHz
// RULE4: Revision 0 toggles CRS_DV at end
// RULE5: Revision 1 holds CRS_DV until drained
// RULE6: Overflow bit reads 0 after overflow
// RULE7: Underflow bit reads 0 after underflow
// RULE8: Received data pass an elasticity buffer
// RULE9: Size code picks 14, 2, 6, 10 bits
// RULE10: Integrator halves lengths at 100ppm; no integrator here, the size code alone sets the lengths
// RULE11: Size field resets to 1
// RULE12: Write-when-full overflows, read-when-empty underflows
module rrec_top #(
  parameter int DEPTH = `RREC_DEPTH,
  parameter int AW    = 5
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire rrec_pkg::rrec_bus_t bus,
  output logic             [15:0] rdata,
  input  wire logic               rec_clk,
  input  wire rrec_pkg::rrec_rx_t  rec_in,
  input  wire logic               refsel_strap,
  input  wire logic               slave_mode,
  output logic                    crs_dv,
  output logic              [1:0] rxd,
  output logic                    ref_is_50m,
  output logic                    tx_shift_en,
  output logic                    irq
);
  initial begin
    if (DEPTH < 2 * `RREC_TOL0 || DEPTH > (1 << AW))
      $error("rrec_top depth cannot hold the largest tolerance");
  end

  // Control/status storage
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic        ovf_n_r;              // Low once overflow seen
  logic        unf_n_r;              // Low once underflow seen
  logic [`RREC_IRQ_W-1:0] ist_r;     // Sticky interrupt status
  logic [`RREC_IRQ_W-1:0] imask_r;   // Interrupt mask
  logic        strap_done_r;         // Strap captured once

  // Two-flop synchronisers for the outside world
  logic [2:0] rc_s1, rc_s2;          // Link clock and data
  logic       rc_d;                  // Delayed synced clock
  logic       st_s1, st_s2;          // Strap
  logic       sl_s1, sl_s2;          // Slave mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_s1 <= 3'h0;
      rc_s2 <= 3'h0;
      rc_d  <= 1'b0;
      sl_s1 <= 1'b0;
      sl_s2 <= 1'b0;
    end else begin
      rc_s1 <= {rec_clk, rec_in.dv, rec_in.dibit[0]};
      rc_s2 <= rc_s1;
      rc_d  <= rc_s2[2];
      sl_s1 <= slave_mode;
      sl_s2 <= sl_s1;
    end
  end

  // Strap sync keeps running in reset so the pin level is ready at release
  always_ff @(posedge clk) begin
    st_s1 <= refsel_strap;
    st_s2 <= st_s1;
  end

  // Second data bit rides its own synchroniser
  logic d1_s1, d1_s2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      d1_s1 <= 1'b0;
      d1_s2 <= 1'b0;
    end else begin
      d1_s1 <= rec_in.dibit[1];
      d1_s2 <= d1_s1;
    end
  end

  // Rising edge of the recovered clock marks a new dibit
  wire       rec_edge = rc_s2[2] & ~rc_d;
  wire       rec_dv   = rc_s2[1];
  wire [1:0] rec_dib  = {d1_s2, rc_s2[0]};

  // Tolerance decode, used for both fill target and limits
  function automatic logic [4:0] tol_of(input logic [1:0] code);
    unique case (rrec_pkg::rrec_size_t'(code))
      rrec_pkg::RREC_SZ_14: tol_of = `RREC_TOL0;
      rrec_pkg::RREC_SZ_2:  tol_of = `RREC_TOL1;
      rrec_pkg::RREC_SZ_6:  tol_of = `RREC_TOL2;
      rrec_pkg::RREC_SZ_10: tol_of = `RREC_TOL3;
    endcase
  endfunction : tol_of

  wire [1:0] size_code = ctrl_r[`RREC_B_SIZE_HI:`RREC_B_SIZE_LO];
  wire [4:0] tol_bits  = tol_of(size_code);                   // RULE9
  // Tolerance counted in dibits; half before starting, rest as slack
  wire [AW:0] start_lvl = (AW+1)'(tol_bits >> 1);
  wire [AW:0] max_lvl   = (AW+1)'(tol_bits);

  // Buffer pointers and level
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0]   lvl_r;
  logic          run_r;              // Draining toward the MAC
  logic          in_frame_r;         // Write side inside a frame
  logic          tog_r;              // CRS_DV toggle phase
  logic          rd_vld_r;           // Memory read data valid
  logic          crs_r;
  logic [1:0]    rxd_r;

  // Buffer decisions
  wire wr_req  = rec_edge & rec_dv;
  wire full    = lvl_r >= max_lvl;
  wire empty   = lvl_r == '0;
  wire ovf_ev  = wr_req & full;                               // RULE12
  wire do_wr   = wr_req & ~full;
  wire frame_end = rec_edge & ~rec_dv & in_frame_r;
  // Reads follow the local beat; drift against the link is what the buffer absorbs
  logic [`RREC_BEAT_W-1:0] beat_r;   // Local read beat counter
  wire rd_tick = beat_r == `RREC_BEAT_LAST;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) beat_r <= '0;
    else     beat_r <= beat_r + `RREC_BEAT_W'(1);
  end
  wire rd_req  = run_r & rd_tick;
  wire unf_ev  = rd_req & empty & in_frame_r;                 // RULE12
  wire do_rd   = rd_req & ~empty;
  // Stop one beat after the last dibit so the MAC sees it a full beat
  wire drained = rd_tick & run_r & empty & ~in_frame_r;

  logic [1:0] mem_q;
  rrec_mem #(.W(2), .D(DEPTH), .A(AW)) u_mem (                // RULE8
    .clk   (clk),
    .we    (do_wr),
    .waddr (wp_r),
    .wdata (rec_dib),
    .raddr (rp_r),
    .rdata (mem_q)
  );

  // Pointer and level bookkeeping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r       <= '0;
      rp_r       <= '0;
      lvl_r      <= '0;
      run_r      <= 1'b0;
      in_frame_r <= 1'b0;
      rd_vld_r   <= 1'b0;
    end else begin
      if (do_wr) wp_r <= wp_r + 1'b1;
      if (do_rd) rp_r <= rp_r + 1'b1;
      lvl_r      <= lvl_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      rd_vld_r   <= do_rd;
      if (rec_edge) in_frame_r <= rec_dv;
      // Start draining once half the tolerance is banked
      if (!run_r && lvl_r >= start_lvl && lvl_r != '0) run_r <= 1'b1;
      else if (drained) run_r <= 1'b0;
    end
  end

  // Carrier/valid toward the MAC
  wire carrier_gone = run_r & ~in_frame_r;
  wire rev_old      = ctrl_r[`RREC_B_REVSEL];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crs_r <= 1'b0;
      rxd_r <= 2'h0;
      tog_r <= 1'b0;
    end else begin
      if (rd_vld_r) rxd_r <= mem_q;
      if (rec_edge) tog_r <= ~tog_r;
      if (!run_r)
        crs_r <= 1'b0;
      else if (carrier_gone && !rev_old)
        crs_r <= tog_r;                                       // RULE4
      else if (rd_vld_r)
        crs_r <= 1'b1;                                        // RULE5
    end
  end
  assign crs_dv = crs_r;
  assign rxd    = rxd_r;

  // Register port decode
  wire hit_ctrl = bus.addr == `RREC_OFF_CTRL;
  wire hit_ist  = bus.addr == `RREC_OFF_IRQ_STAT;
  wire hit_msk  = bus.addr == `RREC_OFF_IRQ_MASK;
  wire wr_ctrl  = bus.wr & hit_ctrl;
  wire wr_ist   = bus.wr & hit_ist;
  wire wr_msk   = bus.wr & hit_msk;
  // Reading the word re-arms the two health bits afterwards
  wire rd_ctrl  = bus.rd & hit_ctrl;

  // Next control word: writable bits only
  assign ctrl_nxt = (ctrl_r & ~`RREC_CTRL_WMASK) | (bus.wdata & `RREC_CTRL_WMASK);

  // Control word and strap capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r       <= `RREC_CTRL_RST;                         // RULE11
      strap_done_r <= 1'b0;
    end else begin
      if (!strap_done_r) begin
        // Latched after release so the strap is stable
        ctrl_r[`RREC_B_REFSEL] <= st_s2;                      // RULE2
        strap_done_r           <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_r <= ctrl_nxt;                                   // RULE2
      end
    end
  end

  // Health bits: hardware drops, a read re-arms; drop wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Reset word reads 0 in both bits until the first read re-arms them
      ovf_n_r <= 1'b0;
      unf_n_r <= 1'b0;
    end else begin
      if (ovf_ev) ovf_n_r <= 1'b0;                            // RULE6
      else if (rd_ctrl) ovf_n_r <= 1'b1;
      if (unf_ev) unf_n_r <= 1'b0;                            // RULE7
      else if (rd_ctrl) unf_n_r <= 1'b1;
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  wire [`RREC_IRQ_W-1:0] ev_vec = {unf_ev, ovf_ev};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_r   <= '0;
      imask_r <= '0;
    end else begin
      ist_r <= (ist_r & ~(wr_ist ? bus.wdata[`RREC_IRQ_W-1:0] : '0)) | ev_vec;
      if (wr_msk) imask_r <= bus.wdata[`RREC_IRQ_W-1:0];
    end
  end
  assign irq = |(ist_r & imask_r);

  // Read-back view of the control word
  logic [15:0] ctrl_view;
  always_comb begin
    ctrl_view                 = ctrl_r;
    ctrl_view[`RREC_B_OVF]    = ovf_n_r;
    ctrl_view[`RREC_B_UNF]    = unf_n_r;
  end
  wire [15:0] rd_mux = hit_ctrl ? ctrl_view :
                       hit_ist  ? {14'h0000, ist_r} :
                       hit_msk  ? {14'h0000, imask_r} : 16'h0000;

  // Read data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdata <= 16'h0000;
    else     rdata <= bus.rd ? rd_mux : 16'h0000;
  end

  // Reference select: 0 = 25MHz source, 1 = 50MHz oscillator
  assign ref_is_50m  = ctrl_r[`RREC_B_REFSEL];                // RULE3
  // Shift ignored unless acting as RMII slave
  assign tx_shift_en = ctrl_r[`RREC_B_TXSHIFT] & sl_s2;       // RULE1
endmodule : rrec_top

// ==== testbench/rrec_bench.sv ====
`timescale 1ns/1ps
module rrec_bench;
  logic clk, rst, refsel_strap, slave_mode, rec_clk, crs_dv, crs_q, ref_is_50m, tx_shift_en, irq;
  rrec_pkg::rrec_bus_t bus;
  rrec_pkg::rrec_rx_t  rec_in;
  logic [15:0] rdata, rs, ctrl_m;
  logic [1:0]  rxd, st;
  logic [1:0]  exp_q[$];
  logic [1:0]  got_q[$];
  int          err_count, samples_checked, falls;
  rrec_top dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .rec_clk(rec_clk),
    .rec_in(rec_in), .refsel_strap(refsel_strap), .slave_mode(slave_mode), .crs_dv(crs_dv),
    .rxd(rxd), .ref_is_50m(ref_is_50m), .tx_shift_en(tx_shift_en), .irq(irq));
  rrec_link_src src (.rec_clk(rec_clk), .rec_in(rec_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Output dibits taken mid link period
  always @(negedge rec_clk) if (crs_dv) got_q.push_back(rxd);
  always @(posedge clk) begin
    crs_q <= crs_dv;
    if (crs_q && !crs_dv) falls++;
  end
  function automatic logic [15:0] xs();
    rs = rs ^ (rs << 7);
    rs = rs ^ (rs >> 9);
    rs = rs ^ (rs << 8);
    return rs;
  endfunction : xs
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.wr <= 1'b1; bus.addr <= a; bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  // Control reads re-arm both status bits
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    bus.rd <= 1'b1; bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
    if (a == 5'h17) st = 2'h3;
  endtask : rd
  task automatic run(input int gap, input int n, input int h);
    exp_q.delete(); got_q.delete(); falls = 0;
    for (int i = 0; i < n; i++) exp_q.push_back(xs() % 4);
    src.frame(exp_q, gap, h);
    repeat (10) @(posedge clk);
  endtask : run
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    #3000000 err_count++;
    end_of_test();
  end
  initial begin
    rst = 1'b1; bus = '0; refsel_strap = 1'b1; slave_mode = 1'b0; rs = 16'h4C14; st = 2'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(5'h17, 16'h00C1);
    chk(ref_is_50m, 16'h1);
    rd(5'h05, 16'h0000);
    wr(5'h05, 16'hFFFF);
    rd(5'h05, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      ctrl_m = (xs() & 16'h01F0) | c[15:0];
      wr(5'h17, ctrl_m);
      rd(5'h17, ctrl_m | {12'h000, st, 2'h0});
    end
    wr(5'h17, 16'h0100);
    slave_mode <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(tx_shift_en, 16'h1);
    slave_mode <= 1'b0;
    repeat (6) @(posedge clk);
    #1 chk(tx_shift_en, 16'h0);
    chk(ref_is_50m, 16'h0);
    wr(5'h17, 16'h0010);
    run(0, 20, 400);
    chk(falls, 16'h1);
    for (int i = 0; i < 20; i++) chk(i < got_q.size() ? got_q[i] : 2'h0, exp_q[i]);
    wr(5'h17, 16'h0000);
    run(0, 20, 400);
    chk(falls > 1, 16'h1);
    rd(5'h17, 16'h000C);
    wr(5'h1B, 16'h0003);
    run(12, 20, 400);
    chk(irq, 16'h1);
    rd(5'h1A, 16'h0002);
    rd(5'h17, 16'h0008);
    wr(5'h1A, 16'h0002);
    @(posedge clk);
    #1 chk(irq, 16'h0);
    wr(5'h1B, 16'h0000);
    run(12, 20, 400);
    chk(irq, 16'h0);
    rd(5'h1A, 16'h0002);
    wr(5'h1A, 16'h0002);
    // Fast link outruns the local beat and fills the buffer
    run(0, 30, 150);
    rd(5'h1A, 16'h0001);
    rd(5'h17, 16'h0000);
    end_of_test();
  end
endmodule : rrec_bench

// ==== testbench/rrec_link_src.sv ====
`timescale 1ns/1ps
// Recovered-side source; its clock stands still between frames
module rrec_link_src (
  output logic               rec_clk,
  output rrec_pkg::rrec_rx_t rec_in
);
  initial begin
    rec_clk = 1'b0;
    rec_in  = '0;
  end
  // One link edge; idle data flips so it never looks valid
  task automatic beat(input logic v, input logic [1:0] d, input int h);
    rec_in.dv    = v;
    rec_in.dibit = v ? d : ~rec_in.dibit;
    #h rec_clk = 1'b1;
    #h rec_clk = 1'b0;
  endtask : beat
  // Short frames keep well inside the slip budget; a gap stalls the clock to starve
  task automatic frame(input logic [1:0] q[$], input int gap, input int h);
    #25;
    for (int i = 0; i < q.size() + 24; i++) begin
      if (i == 10) #(2 * h * gap);
      beat(i < q.size(), i < q.size() ? q[i] : 2'h0, h);
    end
    rec_in.dv = 1'b0;
  endtask : frame
endmodule : rrec_link_src

// ==== testbench/rrec_props.sv ====
`timescale 1ns/1ps
// Port-level checker for the control block
module rrec_props (
  input wire logic                clk,
  input wire logic                rst,
  input wire rrec_pkg::rrec_bus_t bus,
  input wire logic         [15:0] rdata,
  input wire logic                slave_mode,
  input wire logic                tx_shift_en,
  input wire logic                ref_is_50m,
  input wire logic          [1:0] rxd,
  input wire logic                irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_TXSHIFT: assert property (!slave_mode [*4] |=> !tx_shift_en)
    else $error("clock shift outside slave mode");
  AST_REFSEL: assert property ($past(bus.rd && bus.addr == 5'h17) |-> rdata[7] == $past(ref_is_50m))
    else $error("reference select bit disagrees with output");
  AST_READBACK: assert property ((bus.wr && bus.addr == 5'h17) ##2 (bus.rd && bus.addr == 5'h17)
    |=> rdata[8:4] == $past(bus.wdata[8:4], 3) && rdata[1:0] == $past(bus.wdata[1:0], 3))
    else $error("control bits not written");
  AST_RSVD: assert property ($past(bus.rd && bus.addr == 5'h17) |-> rdata[15:9] == 7'h00)
    else $error("reserved bits set");
  AST_UNMAPPED: assert property ($past(bus.rd && bus.addr != 5'h17 && bus.addr != 5'h1A
    && bus.addr != 5'h1B) |-> rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_IDLE: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  AST_MASKED: assert property ((bus.wr && bus.addr == 5'h1B && bus.wdata[1:0] == 2'h0) |=> ##1 !irq)
    else $error("masked interrupt raised");
  AST_PACE: assert property ($changed(rxd) |=> $stable(rxd) [*3])
    else $error("receive data faster than link");
endmodule : rrec_props

bind rrec_top rrec_props u_props (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
  .slave_mode(slave_mode), .tx_shift_en(tx_shift_en), .ref_is_50m(ref_is_50m),
  .rxd(rxd), .irq(irq));
